// ===== sfi_pkg.sv
// Shared constants, types and checksum function for the sensor command block
`default_nettype none
package sfi_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned SFI_CLK_NS = 10;
  localparam int unsigned SFI_RESET_NS = 2_000_000;
  localparam int unsigned SFI_RESET_CYC = SFI_RESET_NS / SFI_CLK_NS;
  localparam int unsigned SFI_WAKE_NS = 16_000_000;
  localparam int unsigned SFI_WAKE_CYC = SFI_WAKE_NS / SFI_CLK_NS;
  localparam int unsigned SFI_QUARTER_NS = 2500;
  localparam int unsigned SFI_QUARTER_CYC = SFI_QUARTER_NS / SFI_CLK_NS;
  // ---------------------------------------------------------------
  // Addresses and command codes
  // ---------------------------------------------------------------
  localparam logic [6:0] SFI_DEV_ADDR = 7'h28;
  localparam logic [7:0] SFI_GC_ADDR = 8'h00;
  localparam logic [7:0] SFI_GC_RESET = 8'h06;
  localparam logic [15:0] SFI_CMD_SLEEP = 16'h3677;
  localparam logic [15:0] SFI_CMD_IDENT = 16'he102;
  localparam logic [2:0] SFI_ID_WORDS = 3'h6;
  localparam logic [4:0] SFI_ID_BYTES = 5'h12;
  localparam logic [7:0] SFI_CRC_POLY = 8'h31;
  localparam logic [7:0] SFI_CRC_INIT = 8'hff;
  localparam logic [7:0] SFI_IDLE_BYTE = 8'hff;
  // Arbitrary neutral identity values
  localparam logic [31:0] SFI_PRODUCT_DEF = 32'h0a5a0001;
  localparam logic [63:0] SFI_SERIAL_DEF = 64'h0000001234567890;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {MD_IDLE = 2'b00, MD_SLEEP = 2'b01, MD_WAKE = 2'b11, MD_RESET = 2'b10} sfi_mode_type;
  typedef enum logic [1:0] {OP_RESET = 2'h0, OP_SLEEP = 2'h1, OP_WAKE = 2'h2, OP_IDENT = 2'h3} sfi_op_type;
  typedef enum logic [2:0] {K_START = 3'h0, K_WRITE = 3'h1, K_READ = 3'h2, K_STOP = 3'h3, K_END = 3'h4} sfi_step_type;

  // CRC-8 over one 16-bit word, MSB first
  function automatic logic [7:0] sfi_crc8(input logic [15:0] d);
    logic [7:0] c;
    c = SFI_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ SFI_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : sfi_crc8
endpackage : sfi_pkg
`default_nettype wire

// ===== sfi_link_if.sv
// Two-wire link between host and sensor with open-drain resolution
`timescale 1ns/1ps
`default_nettype none
interface sfi_link_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Pull-up wins unless an enabled driver pulls low
  assign scl = ~(host_scl_oe & ~host_scl_out);
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));
  modport host (input scl, input sda, output host_scl_out, output host_scl_oe, output host_sda_out,
                output host_sda_oe);
  modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe);
endinterface : sfi_link_if
`default_nettype wire

// ===== sfi_host.sv
// Host end: sequences reset, sleep, wake polling and identification readout
`timescale 1ns/1ps
`default_nettype none
module sfi_host #(
  parameter int unsigned QUARTER_CYCLES = sfi_pkg::SFI_QUARTER_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  sfi_link_if.host link,
  input wire logic op_valid,
  input wire sfi_pkg::sfi_op_type op_code,
  output logic op_ready,
  output logic done,
  output logic nacked,
  output logic crc_err,
  output logic [31:0] product_num,
  output logic [63:0] serial_num
);
  import sfi_pkg::*;

  typedef enum logic [2:0] {HP_IDLE = 3'b000, HP_FETCH = 3'b001, HP_START = 3'b011, HP_BYTE = 3'b010,
                            HP_STOP = 3'b110} sfi_hphase_type;

  // Step list for each operation: {kind, byte}
  function automatic logic [10:0] step_of(input sfi_op_type op, input logic [3:0] i);
    logic [7:0] aw;
    aw = {SFI_DEV_ADDR, 1'b0};
    step_of = {K_END, 8'h00};
    case (op)
      OP_RESET: step_of = (i == 4'h0) ? {K_START, 8'h00} : (i == 4'h1) ? {K_WRITE, SFI_GC_ADDR} :
                          (i == 4'h2) ? {K_WRITE, SFI_GC_RESET} : (i == 4'h3) ? {K_STOP, 8'h00} : {K_END, 8'h00};
      OP_SLEEP: step_of = (i == 4'h0) ? {K_START, 8'h00} : (i == 4'h1) ? {K_WRITE, aw} :
                          (i == 4'h2) ? {K_WRITE, SFI_CMD_SLEEP[15:8]} : (i == 4'h3) ? {K_WRITE, SFI_CMD_SLEEP[7:0]} :
                          (i == 4'h4) ? {K_STOP, 8'h00} : {K_END, 8'h00};
      OP_WAKE: step_of = (i == 4'h0 || i == 4'h3) ? {K_START, 8'h00} : (i == 4'h1 || i == 4'h4) ? {K_WRITE, aw} :
                         (i == 4'h2 || i == 4'h5) ? {K_STOP, 8'h00} : {K_END, 8'h00};
      default: step_of = (i == 4'h0 || i == 4'h5) ? {K_START, 8'h00} : (i == 4'h1) ? {K_WRITE, aw} :
                         (i == 4'h2) ? {K_WRITE, SFI_CMD_IDENT[15:8]} : (i == 4'h3) ? {K_WRITE, SFI_CMD_IDENT[7:0]} :
                         (i == 4'h4 || i == 4'h8) ? {K_STOP, 8'h00} : (i == 4'h6) ? {K_WRITE, aw | 8'h01} :
                         (i == 4'h7) ? {K_READ, 8'h00} : {K_END, 8'h00};
    endcase
  endfunction : step_of

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sfi_hphase_type ph_reg, ph_next;
  sfi_op_type op_reg, op_next;
  logic [7:0] div_reg, div_next;
  logic [3:0] step_reg, step_next;
  logic [1:0] q_reg, q_next;
  logic [3:0] bitn_reg, bitn_next;
  logic [7:0] tx_reg, tx_next, rx_reg, rx_next;
  logic [4:0] rcnt_reg, rcnt_next;
  logic [1:0] pos_reg, pos_next;
  logic [15:0] word_reg, word_next;
  logic [95:0] id_reg, id_next;
  logic rd_reg, rd_next, abort_reg, abort_next, retry_reg, retry_next;
  logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic ready_reg, ready_next, done_reg, done_next, nack_reg, nack_next, crc_reg, crc_next;
  logic tick, last;
  logic [10:0] st;

  // Next-state logic for the sequencer and bit engine
  always_comb begin
    {ph_next, op_next, step_next, q_next, bitn_next, tx_next, rx_next} = {ph_reg, op_reg, step_reg, q_reg,
                                                                          bitn_reg, tx_reg, rx_reg};
    {rcnt_next, pos_next, word_next, id_next, rd_next} = {rcnt_reg, pos_reg, word_reg, id_reg, rd_reg};
    {abort_next, retry_next, scl_oe_next, sda_oe_next} = {abort_reg, retry_reg, scl_oe_reg, sda_oe_reg};
    {ready_next, nack_next, crc_next} = {ready_reg, nack_reg, crc_reg};
    done_next = 1'b0;
    div_next = (div_reg == 8'(QUARTER_CYCLES - 1)) ? 8'h00 : div_reg + 8'h01;
    tick = (div_reg == 8'h00);
    last = (rcnt_reg == SFI_ID_BYTES - 5'h01);
    st = step_of(op_reg, step_reg);
    case (ph_reg)
      HP_IDLE: begin
        ready_next = 1'b1;
        if (op_valid && ready_reg) begin
          {op_next, step_next, ready_next, nack_next, crc_next} = {op_code, 4'h0, 1'b0, 1'b0, 1'b0};
          {abort_next, retry_next, ph_next} = {1'b0, 1'b0, HP_FETCH};
        end
      end
      HP_FETCH: begin
        {q_next, bitn_next, rcnt_next, pos_next} = {2'h0, 4'h0, 5'h00, 2'h0};
        step_next = step_reg + 4'h1;
        tx_next = st[7:0];
        rd_next = (st[10:8] == K_READ);
        case (sfi_step_type'(st[10:8]))
          K_START: ph_next = HP_START;
          K_WRITE, K_READ: ph_next = HP_BYTE;
          K_STOP: ph_next = HP_STOP;
          default: begin
            {ph_next, done_next, step_next} = {HP_IDLE, 1'b1, step_reg};
          end
        endcase
      end
      HP_START: if (tick) begin
        q_next = q_reg + 2'h1;
        case (q_reg)
          2'h0: sda_oe_next = 1'b0;
          2'h1: scl_oe_next = 1'b0;
          2'h2: sda_oe_next = 1'b1;
          default: {scl_oe_next, ph_next} = {1'b1, HP_FETCH};
        endcase
      end
      HP_BYTE: if (tick) begin
        q_next = q_reg + 2'h1;
        case (q_reg)
          // Data or acknowledge driven while the clock is low
          2'h0: sda_oe_next = (bitn_reg == 4'h8) ? (rd_reg && !last) : (!rd_reg && !tx_reg[7]);
          2'h1: scl_oe_next = 1'b0;
          2'h2: begin
            if (bitn_reg != 4'h8) begin
              rx_next = {rx_reg[6:0], link.sda};
              tx_next = {tx_reg[6:0], 1'b1};
            end else if (!rd_reg && link.sda) begin
              if (op_reg != OP_WAKE) begin
                {abort_next, nack_next} = 2'b11;
              end else if (step_reg == 4'h5) begin
                retry_next = 1'b1;
              end
            end
          end
          default: begin
            scl_oe_next = 1'b1;
            bitn_next = bitn_reg + 4'h1;
            if (bitn_reg == 4'h8) begin
              bitn_next = 4'h0;
              ph_next = abort_reg ? HP_STOP : HP_FETCH;
              if (rd_reg) begin
                rcnt_next = rcnt_reg + 5'h01;
                pos_next = (pos_reg == 2'h2) ? 2'h0 : pos_reg + 2'h1;
                if (pos_reg != 2'h2) begin
                  word_next = {word_reg[7:0], rx_reg};
                end else begin
                  id_next = {id_reg[79:0], word_reg};
                  crc_next = crc_reg | (sfi_crc8(word_reg) != rx_reg);
                end
                if (!last) begin
                  ph_next = HP_BYTE;
                end
              end
            end
          end
        endcase
      end
      HP_STOP: if (tick) begin
        q_next = q_reg + 2'h1;
        case (q_reg)
          2'h0: sda_oe_next = 1'b1;
          2'h1: scl_oe_next = 1'b0;
          2'h2: sda_oe_next = 1'b0;
          default: begin
            ph_next = HP_FETCH;
            if (abort_reg) begin
              {ph_next, done_next} = {HP_IDLE, 1'b1};
            end else if (retry_reg) begin
              {step_next, retry_next} = {4'h3, 1'b0};
            end
          end
        endcase
      end
      default: ph_next = HP_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {ph_reg, op_reg, div_reg, step_reg, q_reg, bitn_reg} <= {HP_IDLE, OP_RESET, 8'h00, 4'h0, 2'h0, 4'h0};
      {tx_reg, rx_reg, rcnt_reg, pos_reg, word_reg, id_reg} <= '0;
      {rd_reg, abort_reg, retry_reg, scl_oe_reg, sda_oe_reg} <= 5'h00;
      {ready_reg, done_reg, nack_reg, crc_reg} <= 4'h0;
    end else begin
      {ph_reg, op_reg, div_reg, step_reg, q_reg, bitn_reg} <= {ph_next, op_next, div_next, step_next, q_next,
                                                               bitn_next};
      {tx_reg, rx_reg, rcnt_reg, pos_reg, word_reg, id_reg} <= {tx_next, rx_next, rcnt_next, pos_next, word_next,
                                                                id_next};
      {rd_reg, abort_reg, retry_reg, scl_oe_reg, sda_oe_reg} <= {rd_next, abort_next, retry_next, scl_oe_next,
                                                                 sda_oe_next};
      {ready_reg, done_reg, nack_reg, crc_reg} <= {ready_next, done_next, nack_next, crc_next};
    end
  end

  assign link.host_scl_out = 1'b0;
  assign link.host_sda_out = 1'b0;
  assign link.host_scl_oe = scl_oe_reg;
  assign link.host_sda_oe = sda_oe_reg;
  assign {op_ready, done, nacked, crc_err} = {ready_reg, done_reg, nack_reg, crc_reg};
  assign product_num = id_reg[95:64];
  assign serial_num = id_reg[63:0];
endmodule : sfi_host
`default_nettype wire

// ===== sfi_device.sv
// Device end: two-wire target handling soft reset, sleep, wake-up and identification readout
`timescale 1ns/1ps
`default_nettype none
// Function
// - General call address then reset byte 06
// - Reset window ignores own address and commands
// - Sleep entered only from idle state
// - General call reset ignored while sleeping
// - Host sends sleep only after stopping measurement; sfi_host sends it on any request, device refuses it
// - Own address with write bit wakes device
// - Wake address unacknowledged; host polls until ready
// - Identification accepted only when idle
// - Host writes identification command before reading
// - Eighteen bytes, words MSB first plus CRC
// - Product number 32 bits, revision lowest byte
// - Last four words carry 64-bit serial
// - CRC 0x31, init FF, two bytes only
// - Measuring refuses all but reset and update; device refuses only sleep and identification codes
module sfi_device #(
  parameter logic [31:0] PRODUCT_NUM = sfi_pkg::SFI_PRODUCT_DEF,
  parameter logic [63:0] SERIAL_NUM = sfi_pkg::SFI_SERIAL_DEF,
  parameter int unsigned RESET_CYCLES = sfi_pkg::SFI_RESET_CYC,
  parameter int unsigned WAKE_CYCLES = sfi_pkg::SFI_WAKE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  sfi_link_if.device link,
  input wire logic meas_running,
  output sfi_pkg::sfi_mode_type mode,
  output logic soft_reset_pulse,
  output logic cmd_refused
);
  import sfi_pkg::*;

  typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_ACK = 3'b011, ST_RX = 3'b010,
                            ST_TX = 3'b110, ST_TACK = 3'b111} sfi_bus_type;

  // ---------------------------------------------------------------
  // Readout byte selection
  // ---------------------------------------------------------------
  // Byte at word w, position p (0 high, 1 low, 2 checksum)
  function automatic logic [7:0] id_byte(input logic ready, input logic [2:0] w, input logic [1:0] p);
    logic [95:0] ids;
    logic [15:0] wd;
    ids = {PRODUCT_NUM, SERIAL_NUM};
    wd = ids[95 - 16 * w -: 16];
    if (!ready || w >= SFI_ID_WORDS) begin
      id_byte = SFI_IDLE_BYTE;
    end else if (p == 2'h2) begin
      id_byte = sfi_crc8(wd);
    end else begin
      id_byte = (p == 2'h0) ? wd[15:8] : wd[7:0];
    end
  endfunction : id_byte

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sfi_bus_type st_reg, st_next;
  sfi_mode_type mode_reg, mode_next;
  logic scl_q_reg, sda_q_reg;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next, tx_reg, tx_next, cmd_hi_reg, cmd_hi_next;
  logic [1:0] cnt_reg, cnt_next, pos_reg, pos_next;
  logic [2:0] word_reg, word_next;
  logic [23:0] tmr_reg, tmr_next;
  logic gc_reg, gc_next, rw_reg, rw_next, ack_reg, ack_next, idr_reg, idr_next;
  logic oe_reg, oe_next, rstp_reg, rstp_next, ref_reg, ref_next;
  logic rise, fall, start, stop;
  logic [7:0] b;
  logic [15:0] code;

  // Next-state logic for link engine, mode and readout pointer
  always_comb begin
    {st_next, mode_next, bit_next, sh_next, tx_next, cmd_hi_next} = {st_reg, mode_reg, bit_reg, sh_reg, tx_reg,
                                                                     cmd_hi_reg};
    {cnt_next, pos_next, word_next, tmr_next} = {cnt_reg, pos_reg, word_reg, tmr_reg};
    {gc_next, rw_next, ack_next, idr_next, oe_next} = {gc_reg, rw_reg, ack_reg, idr_reg, oe_reg};
    rstp_next = 1'b0;
    ref_next = 1'b0;
    rise = link.scl && !scl_q_reg;
    fall = !link.scl && scl_q_reg;
    start = link.scl && scl_q_reg && sda_q_reg && !link.sda;
    stop = link.scl && scl_q_reg && !sda_q_reg && link.sda;
    b = {sh_reg[6:0], link.sda};
    code = {cmd_hi_reg, b};

    // Reset and wake windows time out to idle
    if (tmr_reg != 24'h000000) begin
      tmr_next = tmr_reg - 24'h000001;
    end else if (mode_reg == MD_RESET || mode_reg == MD_WAKE) begin
      mode_next = MD_IDLE;
    end

    if (start) begin
      {st_next, bit_next, oe_next} = {ST_ADDR, 3'h0, 1'b0};
    end else if (stop) begin
      {st_next, oe_next} = {ST_IDLE, 1'b0};
    end else begin
      case (st_reg)
        // Address and command bytes sampled on clock rise
        ST_ADDR, ST_RX: if (rise) begin
          sh_next = b;
          bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            st_next = ST_ACK;
            if (st_reg == ST_ADDR) begin
              gc_next = (b == SFI_GC_ADDR);
              rw_next = b[0];
              cnt_next = 2'h0;
              ack_next = 1'b0;
              if (mode_reg == MD_SLEEP) begin
                // Only own write address wakes; never acknowledged
                if (b == {SFI_DEV_ADDR, 1'b0}) begin
                  {mode_next, tmr_next} = {MD_WAKE, 24'(WAKE_CYCLES)};
                end
              end else if (mode_reg == MD_IDLE) begin
                ack_next = (b == SFI_GC_ADDR) || (b[7:1] == SFI_DEV_ADDR);
              end
            end else begin
              ack_next = 1'b1;
              if (gc_reg) begin
                if (b == SFI_GC_RESET && cnt_reg == 2'h0) begin
                  {mode_next, tmr_next, idr_next, rstp_next} = {MD_RESET, 24'(RESET_CYCLES), 1'b0, 1'b1};
                end
                cnt_next = 2'h2;
              end else if (cnt_reg == 2'h0) begin
                {cmd_hi_next, cnt_next} = {b, 2'h1};
              end else if (cnt_reg == 2'h1) begin
                cnt_next = 2'h2;
                if (code == SFI_CMD_SLEEP || code == SFI_CMD_IDENT) begin
                  if (meas_running) begin
                    ref_next = 1'b1;
                  end else if (code == SFI_CMD_SLEEP) begin
                    {mode_next, idr_next} = {MD_SLEEP, 1'b0};
                  end else begin
                    {idr_next, word_next, pos_next} = {1'b1, 3'h0, 2'h0};
                  end
                end
              end
            end
          end
        end
        // Acknowledge slot: drive on first fall, release on second
        ST_ACK: if (fall) begin
          if (bit_reg == 3'h0) begin
            {oe_next, bit_next} = {ack_reg, 3'h1};
          end else begin
            {oe_next, bit_next} = {1'b0, 3'h0};
            if (!ack_reg) begin
              st_next = ST_IDLE;
            end else if (rw_reg) begin
              tx_next = id_byte(idr_reg, word_reg, pos_reg);
              oe_next = !tx_next[7];
              st_next = ST_TX;
              {word_next, pos_next} = (pos_reg == 2'h2) ? {word_reg + 3'h1, 2'h0} : {word_reg, pos_reg + 2'h1};
            end else begin
              st_next = ST_RX;
            end
          end
        end
        // Readout bits shifted out MSB first on clock fall
        ST_TX: if (fall) begin
          bit_next = bit_reg + 3'h1;
          tx_next = {tx_reg[6:0], 1'b1};
          oe_next = !tx_next[7];
          if (bit_reg == 3'h7) begin
            {oe_next, st_next} = {1'b0, ST_TACK};
          end
        end
        // Host acknowledge decides whether the next byte follows
        ST_TACK: begin
          if (rise) begin
            ack_next = !link.sda;
          end
          if (fall) begin
            if (ack_reg) begin
              tx_next = id_byte(idr_reg, word_reg, pos_reg);
              oe_next = !tx_next[7];
              st_next = ST_TX;
              {word_next, pos_next} = (pos_reg == 2'h2) ? {word_reg + 3'h1, 2'h0} : {word_reg, pos_reg + 2'h1};
            end else begin
              st_next = ST_IDLE;
            end
            if (word_reg >= SFI_ID_WORDS) begin
              idr_next = 1'b0;
            end
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {st_reg, mode_reg, scl_q_reg, sda_q_reg, bit_reg} <= {ST_IDLE, MD_IDLE, 1'b1, 1'b1, 3'h0};
      {sh_reg, tx_reg, cmd_hi_reg, cnt_reg, pos_reg, word_reg, tmr_reg} <= '0;
      {gc_reg, rw_reg, ack_reg, idr_reg, oe_reg, rstp_reg, ref_reg} <= 7'h00;
    end else begin
      {st_reg, mode_reg, scl_q_reg, sda_q_reg, bit_reg} <= {st_next, mode_next, link.scl, link.sda, bit_next};
      {sh_reg, tx_reg, cmd_hi_reg, cnt_reg, pos_reg, word_reg, tmr_reg} <= {sh_next, tx_next, cmd_hi_next, cnt_next,
                                                                            pos_next, word_next, tmr_next};
      {gc_reg, rw_reg, ack_reg, idr_reg, oe_reg, rstp_reg, ref_reg} <= {gc_next, rw_next, ack_next, idr_next,
                                                                        oe_next, rstp_next, ref_next};
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = oe_reg;
  assign mode = mode_reg;
  assign soft_reset_pulse = rstp_reg;
  assign cmd_refused = ref_reg;
endmodule : sfi_device
`default_nettype wire

// ===== sfi_link_sva.sv
// Concurrent checks on the two-wire link and the device mode outputs
`timescale 1ns/1ps
`default_nettype none
module sfi_link_sva #(
  parameter int unsigned RESET_CYCLES = 50
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic dev_sda_oe,
  input wire sfi_pkg::sfi_mode_type mode,
  input wire logic soft_reset_pulse,
  input wire logic cmd_refused,
  input wire logic meas_running
);
  import sfi_pkg::*;
  logic in_rst;
  logic [31:0] rst_cnt_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  assign in_rst = (mode == MD_RESET);
  // Counts the length of the running reset window
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_reg <= 32'h0;
    end else begin
      rst_cnt_reg <= in_rst ? rst_cnt_reg + 32'h1 : 32'h0;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_opens_window: assert property (soft_reset_pulse |-> ##[0:1] in_rst)
    else $error("soft reset did not open the window");
  a_reset_window_len: assert property (
    $fell(in_rst) |-> rst_cnt_reg + 2 >= RESET_CYCLES && rst_cnt_reg <= RESET_CYCLES + 2)
    else $error("reset window length wrong");
  a_window_no_ack: assert property (in_rst && $past(in_rst, 600) |-> !$rose(dev_sda_oe))
    else $error("acknowledge inside reset window");
  a_sleep_from_idle: assert property (
    $rose(mode == MD_SLEEP) |-> $past(mode) == MD_IDLE && !$past(meas_running))
    else $error("sleep entered from a busy state");
  a_sleep_no_reset: assert property (mode == MD_SLEEP |=> !soft_reset_pulse && !in_rst)
    else $error("soft reset taken while asleep");
  a_wake_from_sleep: assert property ($rose(mode == MD_WAKE) |-> $past(mode) == MD_SLEEP)
    else $error("wake entered from a wrong mode");
  a_wake_no_ack: assert property (mode == MD_WAKE |-> !dev_sda_oe)
    else $error("wake address acknowledged");
  a_refuse_no_change: assert property (cmd_refused |-> meas_running && mode == MD_IDLE ##1 mode == MD_IDLE)
    else $error("refused command changed the mode");
  a_sda_on_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_bit_stands: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
    else $error("device bit too short");
  // Main scenarios reached
  c_reset: cover property (soft_reset_pulse);
  c_wake: cover property ($rose(mode == MD_WAKE));
  c_refused: cover property (cmd_refused);
endmodule : sfi_link_sva
`default_nettype wire

// ===== test_sensor_reset_sleep_identify.sv
// Self-checking bench joining host and device ends over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module test_sensor_reset_sleep_identify;
  import sfi_pkg::*;
  localparam logic [95:0] ID = {32'h13579b2d, 64'h0123456789abcdef}; // Arbitrary values
  localparam int unsigned QUARTER = 25, RST_CYC = 5000; // Shortened link quarter and reset window
  logic clk = 1'h0, sys_rst = 1'h1, op_valid = 1'h0, meas_running = 1'h0, cap = 1'h0;
  logic op_ready, done, nacked, crc_err, srp, refd;
  logic [31:0] product_num, lfsr = 32'he62f;
  logic [63:0] serial_num;
  sfi_op_type op_code = OP_RESET;
  sfi_mode_type mode;
  int errors = 0, samples_checked = 0, cycles = 0, n_rst = 0, n_ref = 0;
  logic bits[$];
  sfi_link_if link ();
  sfi_host #(.QUARTER_CYCLES(QUARTER)) sfi_host_i (.clk(clk), .sys_rst(sys_rst), .link(link), .op_valid(op_valid),
    .op_code(op_code), .op_ready(op_ready), .done(done), .nacked(nacked), .crc_err(crc_err),
    .product_num(product_num), .serial_num(serial_num));
  sfi_device #(.PRODUCT_NUM(ID[95:64]), .SERIAL_NUM(ID[63:0]), .RESET_CYCLES(RST_CYC), .WAKE_CYCLES(3000))
    sfi_device_i (.clk(clk), .sys_rst(sys_rst), .link(link), .meas_running(meas_running), .mode(mode),
    .soft_reset_pulse(srp), .cmd_refused(refd));
  sfi_link_sva #(.RESET_CYCLES(RST_CYC)) sfi_link_sva_i (.clk(clk), .sys_rst(sys_rst), .scl(link.scl),
    .dev_sda_oe(link.dev_sda_oe), .mode(mode), .soft_reset_pulse(srp), .cmd_refused(refd),
    .meas_running(meas_running));
  // Clock, wire capture, event counters and hang guard
  always #5 clk = ~clk;
  always @(posedge link.scl) begin
    if (cap) begin
      bits.push_back(link.sda);
    end
  end
  always @(posedge clk) begin
    n_rst += int'(srp === 1'h1);
    n_ref += int'(refd === 1'h1);
    cycles++;
    if (cycles == 60000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Next state of the random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Issues one host operation after a random gap and waits for its end
  task automatic run_op(input sfi_op_type op);
    lfsr = lfsr_next(lfsr);
    do @(negedge clk); while (op_ready !== 1'h1);
    repeat (lfsr[3:0]) @(negedge clk);
    op_valid = 1'h1;
    op_code = op;
    @(negedge clk);
    op_valid = 1'h0;
    do @(negedge clk); while (done !== 1'h1);
  endtask : run_op
  function automatic logic [7:0] crc_of(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'h0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    end
    return c;
  endfunction : crc_of
  function automatic logic [7:0] byte_at(input int k);
    logic [7:0] b;
    b = 8'h00;
    for (int j = 0; j < 8; j++) begin
      b = {b[6:0], bits[k + j]};
    end
    return b;
  endfunction : byte_at
  // Main sequence
  initial begin
    logic [15:0] w;
    repeat (5) @(negedge clk);
    sys_rst = 1'h0;
    cap = 1'h1;
    run_op(OP_IDENT);
    cap = 1'h0;
    check("write header", byte_at(0), 64'h50);
    check("command msb", byte_at(9), 64'he1);
    check("read header", byte_at(28), 64'h51);
    for (int i = 0; i < 6; i++) begin
      w = ID[95 - 16 * i -: 16];
      check("word msb", byte_at(37 + 27 * i), w[15:8]);
      check("word lsb", byte_at(46 + 27 * i), w[7:0]);
      check("crc byte", byte_at(55 + 27 * i), crc_of(w));
    end
    check("product", product_num, ID[95:64]);
    check("serial", serial_num, ID[63:0]);
    check("crc flag", crc_err, 64'h0);
    $display("identify test done");
    meas_running = 1'h1;
    run_op(OP_SLEEP);
    meas_running = 1'h0;
    check("refused", n_ref, 64'h1);
    check("mode refused", mode, MD_IDLE);
    $display("refuse test done");
    run_op(OP_RESET);
    check("reset pulse", n_rst, 64'h1);
    check("reset mode", mode, MD_RESET);
    run_op(OP_IDENT);
    check("nack in window", nacked, 64'h1);
    do @(negedge clk); while (mode !== MD_IDLE);
    $display("reset test done");
    run_op(OP_SLEEP);
    check("sleep", mode, MD_SLEEP);
    run_op(OP_RESET);
    check("reset asleep", n_rst, 64'h1);
    check("still asleep", mode, MD_SLEEP);
    run_op(OP_WAKE);
    check("woken", mode, MD_IDLE);
    check("wake abort", nacked, 64'h0);
    $display("sleep test done");
    conclude();
  end
endmodule : test_sensor_reset_sleep_identify
`default_nettype wire
